/* File: test/arsf_core_model.sv */
// Behavioural conversion core that finishes each conversion two cycles on.
`timescale 1ns/1ps
`default_nettype none
module arsf_core_model (
    // Clock and reset.
    input  wire  logic                        sys_clk,
    input  wire  logic                        reset,
    // Start requests from the bench and from the block.
    input  wire  logic                        go,
    input  wire  logic                        conv_start,
    input  wire  logic [2:0]                  ch,
    input  wire  logic [arsf_pkg::RES_W-1:0]  res,
    // Conversion results.
    output logic                              conv_done,
    output logic [2:0]                        conv_chan,
    output logic [arsf_pkg::RES_W-1:0]        conv_result,
    output logic                              conv_busy
);
    logic [1:0] cnt_ff;

    // Outside a conversion the channel and result lines toggle every cycle, except while conv_done is high.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_ff      <= 2'h0;
            conv_done   <= 1'b0;
            conv_busy   <= 1'b0;
            conv_chan   <= 3'h0;
            conv_result <= '0;
        end else begin
            conv_done <= 1'b0;
            if (go || conv_start) begin
                conv_busy   <= 1'b1;
                cnt_ff      <= 2'h2;
                conv_chan   <= ch;
                conv_result <= res;
            end else if (conv_busy && cnt_ff == 2'h1) begin
                conv_busy <= 1'b0;
                conv_done <= 1'b1;
            end else if (conv_busy) begin
                cnt_ff <= cnt_ff - 2'h1;
            end else if (!conv_done) begin
                conv_chan   <= ~conv_chan;
                conv_result <= ~conv_result;
            end
        end
    end
endmodule : arsf_core_model
`default_nettype wire

/* File: test/arsf_top_tb.sv */
// Self-checking bench for the result flags and deferred sleep.
`timescale 1ns/1ps
`default_nettype none
module arsf_top_tb;
    localparam logic [3:0] a_stat = arsf_pkg::OFF_STATUS;
    localparam logic [3:0] a_last = arsf_pkg::OFF_LAST;
    logic        sys_clk   = 1'b0;
    logic        reset     = 1'b1;
    logic [3:0]  reg_addr  = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        go        = 1'b0;
    logic [2:0]  ch        = 3'h0;
    logic [9:0]  res       = 10'h0;
    logic [31:0] reg_rdata;
    logic [31:0] rd_val;
    logic        conv_done;
    logic        conv_busy;
    logic        conv_start;
    logic        sleep_now;
    logic        irq;
    logic [2:0]  conv_chan;
    logic [9:0]  conv_result;
    int          n_errors  = 0;
    int          n_checks  = 0;

    always #5 sys_clk = ~sys_clk;

    arsf_top uut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .conv_done(conv_done), .conv_chan(conv_chan),
        .conv_result(conv_result), .conv_busy(conv_busy),
        .conv_start(conv_start), .sleep_now(sleep_now), .irq(irq));

    arsf_core_model core (.sys_clk(sys_clk), .reset(reset), .go(go),
        .conv_start(conv_start), .ch(ch), .res(res), .conv_done(conv_done),
        .conv_chan(conv_chan), .conv_result(conv_result),
        .conv_busy(conv_busy));

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One register cycle; read data are taken in the cycle after the strobe.
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr    <= w;
        reg_rd    <= !w;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask : acc

    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0);
        chk(rd_val, exp);
    endtask : rdchk

    task automatic fire(input logic [2:0] c, input logic [9:0] r);
        @(posedge sys_clk);
        go  <= 1'b1;
        ch  <= c;
        res <= r;
        @(posedge sys_clk);
        go <= 1'b0;
    endtask : fire

    task automatic conv(input logic [2:0] c, input logic [9:0] r);
        fire(c, r);
        repeat (4) @(posedge sys_clk);
    endtask : conv

    // The register strobe is sampled at the same edge as the end of conversion.
    task automatic hit(input logic [2:0] c, input logic [9:0] r, input logic w,
                       input logic [3:0] a, input logic [31:0] d);
        fire(c, r);
        @(posedge sys_clk);
        acc(w, a, d);
    endtask : hit

    task automatic t_basic;
        rdchk(a_stat, 32'h0);
        acc(1'b1, arsf_pkg::OFF_CH_EN, 32'h0f);
        conv(3'h1, 10'h155);
        rdchk(a_stat, 32'h0001_0002);
        rdchk(4'h9, 32'h155);
        rdchk(a_stat, 32'h0001_0000);
        rdchk(a_last, 32'h0001_0155);
        rdchk(a_stat, 32'h0);
    endtask : t_basic

    task automatic t_third;
        conv(3'h3, 10'h033);
        conv(3'h0, 10'h200);
        rdchk(a_stat, 32'h0003_0009);
        hit(3'h1, 10'h111, 1'b0, 4'hb, 32'h0);
        chk(rd_val, 32'h033);
        rdchk(a_stat, 32'h0003_0003);
        rdchk(a_last, 32'h0001_0111);
        hit(3'h2, 10'h222, 1'b0, 4'h8, 32'h0);
        chk(rd_val, 32'h200);
        rdchk(a_stat, 32'h0001_0004);
    endtask : t_third

    task automatic t_overrun;
        hit(3'h2, 10'h0aa, 1'b0, 4'h8, 32'h0);
        chk(rd_val, 32'h200);
        rdchk(a_stat, 32'h0003_0404);
        hit(3'h2, 10'h0bb, 1'b1, arsf_pkg::OFF_CH_DIS, 32'h01);
        rdchk(a_stat, 32'h0003_0404);
        rdchk(4'ha, 32'h0bb);
        rdchk(a_last, 32'h0002_00bb);
        acc(1'b1, arsf_pkg::OFF_CH_EN, 32'h01);
    endtask : t_overrun

    task automatic t_race;
        conv(3'h2, 10'h011);
        conv(3'h2, 10'h012);
        rdchk(a_last, 32'h0002_0012);
        hit(3'h2, 10'h013, 1'b0, a_stat, 32'h0);
        chk(rd_val, 32'h0002_0400);
        rdchk(a_stat, 32'h0001_0004);
        hit(3'h1, 10'h014, 1'b0, a_stat, 32'h0);
        chk(rd_val, 32'h0001_0004);
        rdchk(a_stat, 32'h0003_0006);
        rdchk(a_last, 32'h0001_0014);
        fire(3'h0, 10'h3ff);
        acc(1'b1, arsf_pkg::OFF_CH_DIS, 32'h01);
        repeat (3) @(posedge sys_clk);
        rdchk(a_stat, 32'h0000_0004);
        rdchk(a_last, 32'h0001_0014);
        conv(3'h2, 10'h015);
        hit(3'h0, 10'h3fe, 1'b0, a_last, 32'h0);
        chk(rd_val, 32'h0002_0015);
        rdchk(a_stat, 32'h0000_0400);
        rdchk(arsf_pkg::OFF_CH_STAT, 32'h0e);
    endtask : t_race

    task automatic t_irq;
        chk({31'h0, irq}, 32'h0);
        acc(1'b1, arsf_pkg::OFF_IRQ_CLR, 32'h3);
        acc(1'b1, arsf_pkg::OFF_IRQ_EN, 32'h1);
        rdchk(arsf_pkg::OFF_IRQ_EN, 32'h1);
        chk({31'h0, irq}, 32'h0);
        conv(3'h3, 10'h055);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        acc(1'b1, arsf_pkg::OFF_IRQ_EN, 32'h2);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        conv(3'h3, 10'h056);
        chk({31'h0, irq}, 32'h1);
        acc(1'b1, arsf_pkg::OFF_IRQ_CLR, 32'h2);
        chk({31'h0, irq}, 32'h0);
    endtask : t_irq

    task automatic t_sleep;
        int i;
        acc(1'b1, arsf_pkg::OFF_MODE, 32'h20);
        rdchk(arsf_pkg::OFF_MODE, 32'h20);
        repeat (5) @(posedge sys_clk);
        chk({31'h0, sleep_now}, 32'h0);
        acc(1'b1, arsf_pkg::OFF_CTRL, 32'h2);
        chk({31'h0, conv_start}, 32'h1);
        for (i = 0; i < 20 && sleep_now !== 1'b1; i++) begin
            @(posedge sys_clk);
        end
        chk({31'h0, sleep_now}, 32'h1);
    endtask : t_sleep

    initial begin
        repeat (5000) @(posedge sys_clk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        reset <= 1'b0;
        t_basic();
        t_third();
        t_overrun();
        t_race();
        t_irq();
        t_sleep();
        tally_and_finish();
    end
endmodule : arsf_top_tb
`default_nettype wire

/* File: verilog/arsf_chan.sv */
// One channel: stored result, end-of-conversion flag and overrun flag.
`timescale 1ns/1ps
`default_nettype none
module arsf_chan #(
    parameter int RES_W = 10
) (
    // Clock and reset.
    input  wire  logic             sys_clk,
    input  wire  logic             reset,
    // Events.
    input  wire  logic             store,
    input  wire  logic [RES_W-1:0] result,
    input  wire  logic             clr_eoc,
    input  wire  logic             clr_ovr,
    // State.
    output logic                   eoc_ff,
    output logic                   ovr_ff,
    output logic [RES_W-1:0]       data_ff
);
    if (RES_W < 1) begin : g_bad_width
        $error("arsf_chan: result width must be positive");
    end

    typedef struct packed {
        logic             eoc;
        logic             ovr;
        logic [RES_W-1:0] data;
    } arsf_ch_s;

    arsf_ch_s st_ff;
    arsf_ch_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (clr_eoc) begin
            nxt_st.eoc = 1'b0;
        end
        if (clr_ovr) begin
            nxt_st.ovr = 1'b0;
        end
        // A new result wins over a clear of its own flag.
        if (store) begin
            nxt_st.data = result;
            nxt_st.eoc  = 1'b1;
            if (st_ff.eoc && !clr_eoc) begin
                nxt_st.ovr = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign eoc_ff  = st_ff.eoc;
    assign ovr_ff  = st_ff.ovr;
    assign data_ff = st_ff.data;

    store_sets_eoc_a : assert property (@(posedge sys_clk) disable iff (reset)
        store |=> eoc_ff && data_ff == $past(result))
        else $error("stored result or eoc flag missing");
endmodule : arsf_chan
`default_nettype wire

/* File: verilog/arsf_pkg.sv */
// Package with register map, field layout and reset values of the result flags.
package arsf_pkg;
    localparam int          NUM_CH         = 8;
    localparam int          ADDR_W         = 4;
    localparam int          DATA_W         = 32;
    localparam int          RES_W          = 10;
    // Register word indexes; channel reads share index 8 with the clear write.
    localparam logic [3:0]  OFF_CTRL       = 4'h0;
    localparam logic [3:0]  OFF_MODE       = 4'h1;
    localparam logic [3:0]  OFF_CH_EN      = 4'h2;
    localparam logic [3:0]  OFF_CH_DIS     = 4'h3;
    localparam logic [3:0]  OFF_CH_STAT    = 4'h4;
    localparam logic [3:0]  OFF_STATUS     = 4'h5;
    localparam logic [3:0]  OFF_LAST       = 4'h6;
    localparam logic [3:0]  OFF_IRQ_EN     = 4'h7;
    localparam logic [3:0]  OFF_IRQ_CLR    = 4'h8;
    localparam logic [3:0]  OFF_IRQ_STAT   = 4'h9;
    localparam logic [3:0]  OFF_CH_BASE    = 4'h8;
    // Status and last-result register field positions.
    localparam int          POS_EOC        = 0;
    localparam int          POS_OVR        = 8;
    localparam int          POS_READY      = 16;
    localparam int          POS_GOVR       = 17;
    localparam int          POS_SLEEPING   = 18;
    localparam int          POS_LAST_CH    = 16;
    // Control and mode bit positions.
    localparam int          POS_START      = 1;
    localparam int          POS_SLEEP_SEL  = 5;
    // Interrupt event bit positions.
    localparam int          IRQ_READY      = 0;
    localparam int          IRQ_GOVR       = 1;
    localparam int          IRQ_W          = 2;
    localparam logic [31:0] RST_ZERO       = 32'h0000_0000;
endpackage : arsf_pkg

/* File: verilog/arsf_top.sv */
// Result registers, status flags and deferred sleep of the converter.
// Behaviour
// - Data-ready flag clears only on last-result read, never on channel reads.
// - Data-ready never sets on an event that stores no new result.
// - Enabled-channel end of conversion sets data-ready despite a coincident read.
// - Disable coinciding with another channel's end still stores and sets ready.
// - Reading channel or last-result register clears that channel's eoc flag.
// - A channel read clears only the read channel's eoc flag.
// - Status read with end of conversion still clears or sets general overrun.
// - End of conversion with data-ready set sets general overrun, except on a last-result read.
// - Channel read with other channel's end sets general overrun when due.
// - Disable with other end, eoc and ready set, sets both overruns.
// - Status read clears channel overrun unless a new result finds its eoc still set.
// - Channel disabled mid-conversion gets no eoc; software ignores disabled eoc.
// - Sleep chosen while idle takes effect after the next conversion ends.
`timescale 1ns/1ps
`default_nettype none
module arsf_top #(
    parameter int NUM_CH = arsf_pkg::NUM_CH,
    parameter int RES_W  = arsf_pkg::RES_W
) (
    // Clock and reset.
    input  wire  logic                          sys_clk,
    input  wire  logic                          reset,
    // Register port.
    input  wire  logic [arsf_pkg::ADDR_W-1:0]   reg_addr,
    input  wire  logic [arsf_pkg::DATA_W-1:0]   reg_wdata,
    input  wire  logic                          reg_wr,
    input  wire  logic                          reg_rd,
    output logic [arsf_pkg::DATA_W-1:0]         reg_rdata,
    // Conversion core.
    input  wire  logic                          conv_done,
    input  wire  logic [$clog2(NUM_CH)-1:0]     conv_chan,
    input  wire  logic [RES_W-1:0]              conv_result,
    input  wire  logic                          conv_busy,
    output logic                                conv_start,
    output logic                                sleep_now,
    // Interrupt.
    output logic                                irq
);
    localparam int CW = $clog2(NUM_CH);

    if (NUM_CH < 2 || NUM_CH > 8 || (NUM_CH & (NUM_CH - 1)) != 0
        || RES_W < 1 || RES_W > 16) begin : g_bad_cfg
        $error("arsf_top: unsupported channel count or width");
    end

    typedef struct packed {
        logic [NUM_CH-1:0]           ch_en;
        logic [NUM_CH-1:0]           aborted;
        logic                        ready;
        logic                        govr;
        logic [RES_W-1:0]            last;
        logic [CW-1:0]               last_ch;
        logic                        sleep_sel;
        logic                        sleep_arm;
        logic                        sleeping;
        logic [arsf_pkg::IRQ_W-1:0]  irq_stat;
        logic [arsf_pkg::IRQ_W-1:0]  irq_en;
        logic [arsf_pkg::DATA_W-1:0] rdata;
        logic                        start;
        logic                        irq;
    } arsf_st_s;

    arsf_st_s st_ff;
    arsf_st_s nxt_st;

    // Per-channel signals.
    logic [NUM_CH-1:0] ch_store;
    logic [NUM_CH-1:0] ch_clr_eoc;
    logic [NUM_CH-1:0] ch_eoc;
    logic [NUM_CH-1:0] ch_ovr;
    logic [RES_W-1:0]  ch_data [NUM_CH];

    // Decoded accesses.
    logic              rd_status;
    logic              rd_last;
    logic              rd_chan;
    logic [CW-1:0]     rd_chan_idx;
    logic              wr_dis;
    logic              done_ok;
    logic              any_eoc_before;

    assign rd_status   = reg_rd && reg_addr == arsf_pkg::OFF_STATUS;
    assign rd_last     = reg_rd && reg_addr == arsf_pkg::OFF_LAST;
    assign rd_chan     = reg_rd && reg_addr >= arsf_pkg::OFF_CH_BASE;
    assign rd_chan_idx = CW'(reg_addr - arsf_pkg::OFF_CH_BASE);
    assign wr_dis      = reg_wr && reg_addr == arsf_pkg::OFF_CH_DIS;
    // Only a finish on a channel still enabled and not disabled mid-run
    // stores a result; an aborted conversion stores nothing.
    assign done_ok     = conv_done && st_ff.ch_en[conv_chan]
                         && !st_ff.aborted[conv_chan];
    assign any_eoc_before = done_ok && ch_eoc[conv_chan];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            // Clear is taken from the decoded read index or, on a last-result read, from the last channel.
            assign ch_store[gi]   = done_ok && conv_chan == CW'(gi);
            assign ch_clr_eoc[gi] = (rd_chan && rd_chan_idx == CW'(gi))
                || (rd_last && st_ff.last_ch == CW'(gi));
            arsf_chan #(
                .RES_W (RES_W)
            ) u_chan (
                .sys_clk (sys_clk),
                .reset   (reset),
                .store   (ch_store[gi]),
                .result  (conv_result),
                .clr_eoc (ch_clr_eoc[gi]),
                .clr_ovr (rd_status),
                .eoc_ff  (ch_eoc[gi]),
                .ovr_ff  (ch_ovr[gi]),
                .data_ff (ch_data[gi])
            );
        end
    endgenerate

    localparam int DATA_W_L = arsf_pkg::DATA_W;
    logic [DATA_W_L-1:0] status_word;

    always_comb begin
        status_word = '0;
        status_word[arsf_pkg::POS_EOC +: NUM_CH]  = ch_eoc;
        status_word[arsf_pkg::POS_OVR +: NUM_CH]  = ch_ovr;
        status_word[arsf_pkg::POS_READY]          = st_ff.ready;
        status_word[arsf_pkg::POS_GOVR]           = st_ff.govr;
        status_word[arsf_pkg::POS_SLEEPING]       = st_ff.sleeping;
    end

    always_comb begin
        nxt_st       = st_ff;
        nxt_st.start = 1'b0;
        // Read data, valid only in the cycle after the read strobe.
        nxt_st.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                arsf_pkg::OFF_MODE: begin
                    nxt_st.rdata[arsf_pkg::POS_SLEEP_SEL] = st_ff.sleep_sel;
                end
                arsf_pkg::OFF_CH_STAT: begin
                    nxt_st.rdata[NUM_CH-1:0] = st_ff.ch_en;
                end
                arsf_pkg::OFF_STATUS: begin
                    nxt_st.rdata = status_word;
                end
                arsf_pkg::OFF_LAST: begin
                    nxt_st.rdata[RES_W-1:0] = st_ff.last;
                    nxt_st.rdata[arsf_pkg::POS_LAST_CH +: CW] = st_ff.last_ch;
                end
                arsf_pkg::OFF_IRQ_EN: begin
                    nxt_st.rdata[arsf_pkg::IRQ_W-1:0] = st_ff.irq_en;
                end
                default: begin
                    if (rd_chan) begin
                        nxt_st.rdata[RES_W-1:0] = ch_data[rd_chan_idx];
                    end
                end
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                arsf_pkg::OFF_CTRL: begin
                    nxt_st.start = reg_wdata[arsf_pkg::POS_START];
                end
                arsf_pkg::OFF_MODE: begin
                    nxt_st.sleep_sel = reg_wdata[arsf_pkg::POS_SLEEP_SEL];
                end
                arsf_pkg::OFF_CH_EN: begin
                    nxt_st.ch_en = st_ff.ch_en | reg_wdata[NUM_CH-1:0];
                end
                arsf_pkg::OFF_IRQ_EN: begin
                    nxt_st.irq_en = reg_wdata[arsf_pkg::IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end
        // Disable: mark a running conversion on that channel as aborted.
        if (wr_dis) begin
            nxt_st.ch_en = st_ff.ch_en & ~reg_wdata[NUM_CH-1:0];
            if (conv_busy && !conv_done) begin
                nxt_st.aborted = st_ff.aborted
                    | (reg_wdata[NUM_CH-1:0] & (NUM_CH'(1) << conv_chan));
            end
        end
        if (conv_done) begin
            nxt_st.aborted[conv_chan] = 1'b0;
        end
        // Data-ready: cleared only by a last-result read.
        if (rd_last) begin
            nxt_st.ready = 1'b0;
        end
        // General overrun: a status read clears it, a new overrun wins.
        if (rd_status) begin
            nxt_st.govr = 1'b0;
        end
        if (done_ok) begin
            nxt_st.ready   = 1'b1;
            nxt_st.last    = conv_result;
            nxt_st.last_ch = conv_chan;
            if (st_ff.ready && !rd_last) begin
                nxt_st.govr = 1'b1;
            end
            nxt_st.irq_stat[arsf_pkg::IRQ_READY] = 1'b1;
            if (st_ff.ready && !rd_last) begin
                nxt_st.irq_stat[arsf_pkg::IRQ_GOVR] = 1'b1;
            end
        end
        // Sleep armed by selection, entered after the next conversion end.
        if (!st_ff.sleep_sel) begin
            nxt_st.sleep_arm = 1'b0;
            nxt_st.sleeping  = 1'b0;
        end else if (!st_ff.sleep_arm && !st_ff.sleeping) begin
            nxt_st.sleep_arm = 1'b1;
        end
        if (st_ff.sleep_sel && st_ff.sleep_arm && conv_done) begin
            nxt_st.sleeping  = 1'b1;
            nxt_st.sleep_arm = 1'b0;
        end
        if (nxt_st.start) begin
            nxt_st.sleeping = 1'b0;
            nxt_st.sleep_arm = st_ff.sleep_sel;
        end
        // Interrupt clear; a coincident event wins.
        if (reg_wr && reg_addr == arsf_pkg::OFF_IRQ_CLR) begin
            nxt_st.irq_stat = st_ff.irq_stat
                & ~reg_wdata[arsf_pkg::IRQ_W-1:0];
            if (done_ok) begin
                nxt_st.irq_stat[arsf_pkg::IRQ_READY] = 1'b1;
                if (st_ff.ready && !rd_last) begin
                    nxt_st.irq_stat[arsf_pkg::IRQ_GOVR] = 1'b1;
                end
            end
        end
        nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_en);
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata  = st_ff.rdata;
    assign conv_start = st_ff.start;
    assign sleep_now  = st_ff.sleeping;
    assign irq        = st_ff.irq;

    ready_hold_a : assert property (@(posedge sys_clk) disable iff (reset)
        st_ff.ready && !rd_last |=> st_ff.ready)
        else $error("data-ready lost without last-result read");
    ready_no_data_a : assert property (@(posedge sys_clk) disable iff (reset)
        !st_ff.ready && !done_ok |=> !st_ff.ready)
        else $error("data-ready rose without stored result");
    ready_on_done_a : assert property (@(posedge sys_clk) disable iff (reset)
        done_ok |=> st_ff.ready && st_ff.last == $past(conv_result))
        else $error("data-ready or last result missing after finish");
    store_on_dis_a : assert property (@(posedge sys_clk) disable iff (reset)
        done_ok && wr_dis |=> st_ff.ready)
        else $error("disable blocked finished result");
    clr_only_read_a : assert property (@(posedge sys_clk) disable iff (reset)
        rd_chan && !done_ok |=> !ch_eoc[$past(rd_chan_idx)])
        else $error("channel read did not clear its eoc");
    govr_clear_a : assert property (@(posedge sys_clk) disable iff (reset)
        rd_status && !done_ok |=> !st_ff.govr)
        else $error("status read did not clear general overrun");
    govr_set_a : assert property (@(posedge sys_clk) disable iff (reset)
        done_ok && st_ff.ready && !rd_last |=> st_ff.govr)
        else $error("general overrun not set");
    no_eoc_abort_a : assert property (@(posedge sys_clk) disable iff (reset)
        conv_done && !st_ff.ch_en[conv_chan] && !ch_eoc[conv_chan]
        |=> !ch_eoc[$past(conv_chan)])
        else $error("eoc set for disabled channel");
    ovr_clear_a : assert property (@(posedge sys_clk) disable iff (reset)
        rd_status |=> ch_ovr == '0 || $past(any_eoc_before))
        else $error("status read left channel overrun set");

    // Named steps of the multi-step checks below.
    sequence s_again_done;
        done_ok && ch_eoc[conv_chan] && !ch_clr_eoc[conv_chan];
    endsequence
    sequence s_sleep_armed;
        st_ff.sleep_sel && st_ff.sleep_arm && !nxt_st.start;
    endsequence
    sequence s_aborted_done;
        conv_done && st_ff.aborted[conv_chan] && !ch_eoc[conv_chan];
    endsequence
    sequence s_last_stored;
        st_ff.last_ch == $past(conv_chan)
            && ch_data[$past(conv_chan)] == $past(conv_result);
    endsequence

    // Result storage and flag checks.
    ready_keep_a : assert property (@(posedge sys_clk) disable iff (reset)
        st_ff.ready && rd_chan |=> st_ff.ready)
        else $error("channel read cleared data-ready");
    ready_on_read_a : assert property (@(posedge sys_clk) disable iff (reset)
        done_ok && rd_chan |=> st_ff.ready)
        else $error("data-ready lost beside a channel read");
    last_on_dis_a : assert property (@(posedge sys_clk) disable iff (reset)
        done_ok && wr_dis |=> s_last_stored)
        else $error("finished result not stored beside a disable");
    last_clr_eoc_a : assert property (@(posedge sys_clk) disable iff (reset)
        rd_last && !done_ok |=> !ch_eoc[$past(st_ff.last_ch)])
        else $error("last-result read did not clear its eoc");
    eoc_keep_a : assert property (@(posedge sys_clk) disable iff (reset)
        rd_chan && rd_chan_idx != st_ff.last_ch && ch_eoc[st_ff.last_ch]
        |=> ch_eoc[$past(st_ff.last_ch)])
        else $error("channel read cleared another eoc");
    govr_on_read_a : assert property (@(posedge sys_clk) disable iff (reset)
        done_ok && rd_chan && st_ff.ready |=> st_ff.govr)
        else $error("general overrun lost beside a channel read");
    govr_on_dis_a : assert property (@(posedge sys_clk) disable iff (reset)
        done_ok && wr_dis && st_ff.ready |=> st_ff.govr)
        else $error("general overrun lost beside a disable");
    ovr_again_a : assert property (@(posedge sys_clk) disable iff (reset)
        s_again_done |=> ch_ovr[$past(conv_chan)])
        else $error("channel overrun not set on a second result");
    abort_eoc_a : assert property (@(posedge sys_clk) disable iff (reset)
        s_aborted_done |=> !ch_eoc[$past(conv_chan)])
        else $error("eoc set for a conversion aborted by disable");

    // Sleep, start pulse, interrupt mask and read answer.
    sleep_entry_a : assert property (@(posedge sys_clk) disable iff (reset)
        s_sleep_armed ##0 conv_done |=> sleep_now)
        else $error("sleep not entered after a conversion end");
    sleep_wait_a : assert property (@(posedge sys_clk) disable iff (reset)
        !sleep_now && !conv_done |=> !sleep_now)
        else $error("sleep entered without a conversion end");
    start_pulse_a : assert property (@(posedge sys_clk) disable iff (reset)
        !(reg_wr && reg_addr == arsf_pkg::OFF_CTRL) |=> !conv_start)
        else $error("start pulse without a control write");
    irq_mask_a : assert property (@(posedge sys_clk) disable iff (reset)
        st_ff.irq_en == '0 && !(reg_wr && reg_addr == arsf_pkg::OFF_IRQ_EN)
        |=> !irq)
        else $error("interrupt raised while masked");
    rdata_idle_a : assert property (@(posedge sys_clk) disable iff (reset)
        !reg_rd |=> reg_rdata == '0)
        else $error("read data not zero outside a read answer");
endmodule : arsf_top
`default_nettype wire
